// [bench/sacc_ctrl_asserts.sv]
// concurrent checks on the ports of the scratchpad, alarm and chain controller
`default_nettype none
module sacc_chk
(
    input wire i_sys_clk,
    input wire i_srst,
    input wire i_bus_reset,
    input wire i_cmd_valid,
    input wire i_tx_req,
    input wire o_tx_valid,
    input wire i_conv_done,
    input wire i_od_set,
    input wire o_overdrive_speed_flag,
    input wire i_chain_valid,
    input wire [7:0] i_chain_byte,
    input wire o_pio_a_out,
    input wire o_pio_b_out,
    input wire o_pio_a_oe_n,
    input wire o_pio_b_oe_n,
    input wire o_pio_a_pullup_en,
    input wire [1:0] o_pio_latch,
    input wire o_alarm_flag,
    input wire o_cond_read_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);
    sequence s_chain(logic [7:0] code);
        i_chain_valid && i_chain_byte == code;
    endsequence
    // a command or bus reset in the same cycle swallows the request
    sequence s_read_req;
        i_tx_req && !i_cmd_valid && !i_bus_reset;
    endsequence
    a_tx_answer: assert property (s_read_req |=> o_tx_valid)
        else $error("read request got no answer");
    a_tx_cause: assert property (o_tx_valid |-> $past(i_tx_req))
        else $error("read answer without request");
    a_alarm_on_conv: assert property ($changed(o_alarm_flag) |->
        $past(i_conv_done) || $past(i_conv_done, 2))
        else $error("alarm flag moved without conversion");
    a_od_set: assert property (i_od_set |-> ##[1:2] o_overdrive_speed_flag)
        else $error("overdrive flag not set");
    a_od_cause: assert property ($rose(o_overdrive_speed_flag) |->
        $past(i_od_set) || $past(i_od_set, 2))
        else $error("overdrive flag rose by itself");
    a_chain_on: assert property (s_chain(8'h5A) |-> ##[1:2]
        (o_pio_a_pullup_en && o_pio_a_oe_n && o_pio_b_oe_n))
        else $error("chain on pin setup wrong");
    a_chain_done: assert property (s_chain(8'h96) |-> ##[1:2]
        (!o_pio_a_oe_n && !o_pio_a_pullup_en && !o_cond_read_enable))
        else $error("chain done pin setup wrong");
    a_latch_hidden: assert property (o_pio_a_pullup_en |-> o_pio_latch == 2'h3)
        else $error("latch readback visible in chain on");
    a_cond_on_only: assert property (o_cond_read_enable |-> o_pio_a_pullup_en)
        else $error("conditional read outside chain on");
    a_drive_zero: assert property (!o_pio_a_out && !o_pio_b_out)
        else $error("pin drive value not low");
endmodule // sacc_chk
`default_nettype wire

// [bench/sacc_master_model.sv]
// bus master side: function commands, written bytes and read requests
`default_nettype none
module sacc_master_model
(
    input wire logic i_sys_clk,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_byte,
    output logic o_bus_reset,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_byte,
    output logic o_rx_valid,
    output logic [7:0] o_rx_byte,
    output logic o_tx_req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {o_bus_reset, o_cmd_valid, o_rx_valid, o_tx_req} = 4'h0;
        o_cmd_byte = 8'h00;
        o_rx_byte = 8'hFF;
    end
    // kind 0 command, 1 data byte, 2 bus reset; data lines flip once released
    task automatic put(input logic [1:0] kind, input logic [7:0] b);
        @(negedge i_sys_clk);
        o_cmd_valid = (kind == 2'h0);
        o_rx_valid = (kind == 2'h1);
        o_bus_reset = (kind == 2'h2);
        o_cmd_byte = b;
        o_rx_byte = b;
        @(negedge i_sys_clk);
        {o_cmd_valid, o_rx_valid, o_bus_reset} = 3'h0;
        o_cmd_byte = ~b;
        o_rx_byte = ~b;
    endtask
    // all three bytes always follow the command
    task automatic wr_sp(input logic [7:0] h, input logic [7:0] l, input logic [7:0] c);
        put(2'h0, 8'h4E);
        put(2'h1, h);
        put(2'h1, l);
        put(2'h1, c);
    endtask
    // the answer stands for exactly the one cycle after the request
    task automatic get(output logic [7:0] b, output logic v);
        @(negedge i_sys_clk);
        o_tx_req = 1'b1;
        @(negedge i_sys_clk);
        o_tx_req = 1'b0;
        v = i_tx_valid;
        b = i_tx_byte;
        @(negedge i_sys_clk);
        v = v & !i_tx_valid;
    endtask
endmodule // sacc_master_model
`default_nettype wire

// [bench/scratchpad_alarm_chain_ctrl_test.sv]
// self-checking bench of the scratchpad, alarm and chain controller
`include "sacc_map.vh"
`default_nettype none
module scratchpad_alarm_chain_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_conv_done = 1'b0;
    logic [15:0] i_conv_result = 16'h0000;
    logic i_od_set = 1'b0;
    logic i_od_clear = 1'b0;
    logic i_chain_valid = 1'b0;
    logic [7:0] i_chain_byte = 8'h00;
    logic i_pio_wr_valid = 1'b0;
    logic [1:0] i_pio_wr_data = 2'h3;
    logic en_low = 1'b0;
    wire i_bus_reset, i_cmd_valid, i_rx_valid, i_tx_req, o_tx_valid;
    wire [7:0] i_cmd_byte, i_rx_byte, o_tx_byte;
    wire o_pio_a_out, o_pio_a_oe_n, o_pio_a_pullup_en, o_pio_b_out, o_pio_b_oe_n;
    wire o_alarm_flag, o_cond_read_enable, o_overdrive_speed_flag;
    wire o_resolution_select_low, o_resolution_select_high;
    wire [1:0] o_pio_pin_state, o_pio_latch;
    // released pins sit high through their pull-ups
    wire i_pio_a_in = o_pio_a_oe_n;
    wire i_pio_b_in = o_pio_b_oe_n & ~en_low;
    int n_fail = 0;
    int samples_checked = 0;
    logic [7:0] sp [0:7];
    always #5 i_sys_clk = ~i_sys_clk;
    sacc_master_model m (.i_sys_clk, .i_tx_valid(o_tx_valid), .i_tx_byte(o_tx_byte),
        .o_bus_reset(i_bus_reset), .o_cmd_valid(i_cmd_valid), .o_cmd_byte(i_cmd_byte),
        .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte), .o_tx_req(i_tx_req));
    sacc_ctrl dut (.i_sys_clk, .i_srst, .i_bus_reset, .i_cmd_valid, .i_cmd_byte,
        .i_rx_valid, .i_rx_byte, .i_tx_req, .o_tx_valid, .o_tx_byte, .i_conv_done,
        .i_conv_result, .i_od_set, .i_od_clear, .i_chain_valid, .i_chain_byte,
        .i_pio_wr_valid, .i_pio_wr_data, .i_pio_a_in, .i_pio_b_in, .o_pio_a_out,
        .o_pio_a_oe_n, .o_pio_a_pullup_en, .o_pio_b_out, .o_pio_b_oe_n, .o_pio_pin_state,
        .o_pio_latch, .o_alarm_flag, .o_cond_read_enable, .o_overdrive_speed_flag,
        .o_resolution_select_low, .o_resolution_select_high);
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [7:0] crc8();
        logic [7:0] c;
        logic fb;
        c = 8'h00;
        for (int i = 0; i < 8; i++)
            for (int k = 0; k < 8; k++)
            begin
                fb = c[0] ^ sp[i][k];
                c = (c >> 1) ^ (fb ? 8'h8C : 8'h00);
            end
        return c;
    endfunction
    function automatic logic alarm_of(input logic [15:0] r);
        logic signed [7:0] t;
        t = {r[15], r[10:4]};
        return t >= $signed(sp[2]) || t <= $signed(sp[3]);
    endfunction
    task automatic read_sp(input int n);
        logic [7:0] b;
        logic v;
        m.put(2'h0, `SACC_CMD_READ_SP);
        for (int i = 0; i < n; i++)
        begin
            m.get(b, v);
            chk("tx_valid", 8'h01, {7'h00, v});
            chk("tx_byte", i < 8 ? sp[i] : crc8(), b);
        end
    endtask
    // ch high: chain control byte, low: pio latch write
    task automatic side(input logic ch, input logic [7:0] b);
        @(negedge i_sys_clk);
        i_chain_valid = ch;
        i_pio_wr_valid = !ch;
        i_chain_byte = b;
        i_pio_wr_data = b[1:0];
        @(negedge i_sys_clk);
        {i_chain_valid, i_pio_wr_valid} = 2'h0;
        i_chain_byte = ~b;
        repeat (6) @(negedge i_sys_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #500000;
        n_fail++;
        end_sim();
    end
    initial
    begin
        logic [15:0] r;
        logic [10:0] x;
        logic [7:0] c;
        void'($urandom(32'h630C));
        sp = '{8'h50, 8'h05, 8'h55, 8'h00, 8'h7F, 8'hFF, 8'h0C, 8'h10};
        repeat (10) @(negedge i_sys_clk);
        i_srst = 1'b0;
        chk("alarm", 8'h00, {7'h00, o_alarm_flag});
        chk("od", 8'h00, {7'h00, o_overdrive_speed_flag});
        chk("res", 8'h03, {6'h00, o_resolution_select_high, o_resolution_select_low});
        chk("oe_n", 8'h03, {6'h00, o_pio_b_oe_n, o_pio_a_oe_n});
        read_sp(9);
        $display("test reset done");
        for (int k = 0; k < 6; k++)
        begin
            c = 8'($urandom);
            c[6:5] = k[1:0];
            sp[2] = k < 3 ? 8'($urandom) : 8'h20;
            sp[3] = k < 3 ? 8'($urandom) : 8'hF0;
            sp[4] = {1'b0, k[1:0], 5'h1F};
            m.wr_sp(sp[2], sp[3], c);
            x = 11'($urandom);
            r = {{5{x[10]}}, x};
            // corner cases: strictly inside, equal to high, equal to low
            if (k == 3)
                r[15:4] = 12'h010;
            if (k == 4)
                r[15:4] = 12'h020;
            if (k == 5)
                r[15:4] = 12'hFF0;
            @(negedge i_sys_clk);
            i_conv_done = 1'b1;
            i_conv_result = r;
            @(negedge i_sys_clk);
            i_conv_done = 1'b0;
            i_conv_result = ~r;
            repeat (2) @(negedge i_sys_clk);
            chk("alarm", {7'h00, alarm_of(r)}, {7'h00, o_alarm_flag});
            {sp[1], sp[0]} = r;
            read_sp(k == 1 ? 4 : 9);
            if (k == 1)
            begin
                m.put(2'h2, 8'h00);
                read_sp(9);
            end
            chk("res", {6'h00, k[1:0]},
                {6'h00, o_resolution_select_high, o_resolution_select_low});
        end
        $display("test scratchpad and alarm done");
        c = 8'($urandom);
        side(1'b0, c);
        chk("oe_n off", {6'h00, c[1:0]}, {6'h00, o_pio_b_oe_n, o_pio_a_oe_n});
        chk("latch off", {6'h00, c[1:0]}, {6'h00, o_pio_latch});
        chk("pin state", {6'h00, c[1:0]}, {6'h00, o_pio_pin_state});
        en_low = 1'b1;
        side(1'b1, 8'h5A);
        chk("pullup", 8'h01, {7'h00, o_pio_a_pullup_en});
        chk("latch on", 8'h03, {6'h00, o_pio_latch});
        chk("cond en low", 8'h01, {7'h00, o_cond_read_enable});
        side(1'b0, 8'h00);
        chk("oe_n on", 8'h03, {6'h00, o_pio_b_oe_n, o_pio_a_oe_n});
        en_low = 1'b0;
        side(1'b1, 8'h77);
        chk("cond en high", 8'h00, {7'h00, o_cond_read_enable});
        chk("pullup kept", 8'h01, {7'h00, o_pio_a_pullup_en});
        en_low = 1'b1;
        side(1'b1, 8'h96);
        chk("done", 8'h02, {6'h00, o_pio_b_oe_n, o_pio_a_oe_n});
        chk("cond done", 8'h00, {7'h00, o_cond_read_enable});
        side(1'b1, 8'h3C);
        chk("oe_n back", {6'h00, c[1:0]}, {6'h00, o_pio_b_oe_n, o_pio_a_oe_n});
        $display("test chain done");
        @(negedge i_sys_clk);
        i_od_set = 1'b1;
        @(negedge i_sys_clk);
        i_od_set = 1'b0;
        i_od_clear = 1'b1;
        @(negedge i_sys_clk);
        chk("od set", 8'h01, {7'h00, o_overdrive_speed_flag});
        i_od_clear = 1'b0;
        repeat (2) @(negedge i_sys_clk);
        chk("od clear", 8'h00, {7'h00, o_overdrive_speed_flag});
        // set and clear in one cycle: set wins
        @(negedge i_sys_clk);
        {i_od_set, i_od_clear} = 2'h3;
        @(negedge i_sys_clk);
        {i_od_set, i_od_clear} = 2'h0;
        repeat (2) @(negedge i_sys_clk);
        chk("od both", 8'h01, {7'h00, o_overdrive_speed_flag});
        $display("test speed done");
        end_sim();
    end
endmodule // scratchpad_alarm_chain_ctrl_test
bind sacc_ctrl sacc_chk u_chk (.i_sys_clk, .i_srst, .i_bus_reset, .i_cmd_valid,
    .i_tx_req, .o_tx_valid, .i_conv_done, .i_od_set, .o_overdrive_speed_flag,
    .i_chain_valid, .i_chain_byte, .o_pio_a_out, .o_pio_b_out, .o_pio_a_oe_n,
    .o_pio_b_oe_n, .o_pio_a_pullup_en, .o_pio_latch, .o_alarm_flag, .o_cond_read_enable);
`default_nettype wire

// [core/sacc_alarm.v]
// threshold comparison of a conversion result
`default_nettype none

module sacc_alarm
(
    input wire [15:0] i_temp,
    input wire [7:0] i_high_th,
    input wire [7:0] i_low_th,
    output wire o_alarm_hit
);

    // fractional bits are dropped, so 24.9 compares as 24
    wire [7:0] int_part;
    assign int_part = {i_temp[15], i_temp[10:4]};

    assign o_alarm_hit = ($signed(int_part) >= $signed(i_high_th))
        || ($signed(int_part) <= $signed(i_low_th));

endmodule // sacc_alarm
`default_nettype wire

// [core/sacc_crc8.v]
// byte-wise crc accumulator for the scratchpad read
`include "sacc_map.vh"
`default_nettype none

module sacc_crc8
(
    input wire i_sys_clk,
    input wire i_srst,
    input wire i_clr,
    input wire i_en,
    input wire [7:0] i_byte,
    output reg [7:0] o_crc
);

    // lsb first, one bit per loop turn, same result as the serial shifter
    function [7:0] crc_step;
        input [7:0] c_in;
        input [7:0] b_in;
        reg [7:0] c;
        reg fb;
        integer k;
        begin
            c = c_in;
            for (k = 0; k < 8; k = k + 1)
            begin
                fb = c[0] ^ b_in[k];
                c = {1'b0, c[7:1]};
                if (fb)
                    c = c ^ `SACC_CRC_POLY;
            end
            crc_step = c;
        end
    endfunction

    always @(posedge i_sys_clk)
    begin
        if (i_srst || i_clr)
            o_crc <= `SACC_CRC_INIT;
        else if (i_en)
            o_crc <= crc_step(o_crc, i_byte);
    end

endmodule // sacc_crc8
`default_nettype wire

// [core/sacc_ctrl.v]
// device function logic: scratchpad, alarm, resolution, pio latches, chain
//
// Overview of operation
// - each finished conversion is compared against the high and low thresholds.
// - thresholds are 8-bit two's complement values, one degree per step.
// - alarm sets when result is at or above high, or at or below low.
// - alarm stays set until a later reading lies strictly between thresholds.
// - config bits 6:5 select 9, 10, 11 or 12 bit resolution.
// - config bit 7 reads 0, bits 4:0 read 1, writes ignored.
// - configuration starts at 12-bit resolution.
// - each pin pulldown follows its own latch; latches start with pulldowns off.
// - three chain states, off after reset; in off only pio commands rule pins.
// - chain on: done pin pull-up on, other pin is active-low enable.
// - conditional read answered only in chain on with enable low.
// - chain done: done pin pulled low, enable ignored, no conditional read.
// - standard speed after reset; overdrive only when explicitly selected.
// - write command 4Eh takes high, low, config bytes into bytes 2-4.
// - read command BEh sends bytes 0 to 7 in order, lsb first.
// - a ninth read byte carries the crc of the eight scratchpad bytes.
// - a bus reset abandons any transfer and returns to idle.
// - crc uses x8+x5+x4+1, starts at zero, lsb first.
// - temperature held as 16-bit sign-extended value, four fraction bits.
// - chain codes 3Ch off, 5Ah on, 96h done; others change nothing.
`include "sacc_map.vh"
`default_nettype none

module sacc_ctrl
(
    input wire i_sys_clk,
    input wire i_srst,
    input wire i_bus_reset,
    input wire i_cmd_valid,
    input wire [7:0] i_cmd_byte,
    input wire i_rx_valid,
    input wire [7:0] i_rx_byte,
    input wire i_tx_req,
    output reg o_tx_valid,
    output reg [7:0] o_tx_byte,
    input wire i_conv_done,
    input wire [15:0] i_conv_result,
    input wire i_od_set,
    input wire i_od_clear,
    input wire i_chain_valid,
    input wire [7:0] i_chain_byte,
    input wire i_pio_wr_valid,
    input wire [1:0] i_pio_wr_data,
    input wire i_pio_a_in,
    input wire i_pio_b_in,
    output wire o_pio_a_out,
    output reg o_pio_a_oe_n,
    output reg o_pio_a_pullup_en,
    output wire o_pio_b_out,
    output reg o_pio_b_oe_n,
    output reg [1:0] o_pio_pin_state,
    output reg [1:0] o_pio_latch,
    output reg o_alarm_flag,
    output reg o_cond_read_enable,
    output reg o_overdrive_speed_flag,
    output reg o_resolution_select_low,
    output reg o_resolution_select_high
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WRITE = 2'h1;
    localparam [1:0] ST_READ = 2'h2;
    localparam [3:0] WR_LAST = 4'h2;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg [3:0] idx_q;
    reg [3:0] idx_d;
    reg [15:0] temp_q;
    reg [7:0] high_th_q;
    reg [7:0] low_th_q;
    reg [1:0] res_q;
    reg [1:0] chain_q;
    reg [1:0] chain_d;
    reg [1:0] latch_q;
    reg alarm_q;
    reg od_q;
    reg [2:0] a_sync_q;
    reg [2:0] b_sync_q;
    reg a_pin_q;
    reg b_pin_q;
    reg [7:0] tx_d;
    reg crc_clr;
    reg crc_en;
    wire [7:0] crc_val;
    wire alarm_hit;

    // config byte as seen on the bus, fixed bits forced
    function [7:0] cfg_byte;
        input [1:0] res;
        begin
            cfg_byte = {`SACC_CFG_TOP_BIT, res, `SACC_CFG_FIXED_ONES};
        end
    endfunction

    // scratchpad byte multiplexer, also feeds the crc
    function [7:0] sp_byte;
        input [3:0] idx;
        input [15:0] temp;
        input [7:0] th;
        input [7:0] tl;
        input [1:0] res;
        input [7:0] crc;
        begin
            case (idx)
                `SACC_OFS_TEMP_LSB: sp_byte = temp[7:0];
                `SACC_OFS_TEMP_MSB: sp_byte = temp[15:8];
                `SACC_OFS_HIGH_TH: sp_byte = th;
                `SACC_OFS_LOW_TH: sp_byte = tl;
                `SACC_OFS_CONFIG: sp_byte = cfg_byte(res);
                `SACC_OFS_RSVD5: sp_byte = `SACC_VAL_RSVD5;
                `SACC_OFS_RSVD6: sp_byte = `SACC_VAL_RSVD6;
                `SACC_OFS_RSVD7: sp_byte = `SACC_VAL_RSVD7;
                `SACC_OFS_CRC: sp_byte = crc;
                default: sp_byte = `SACC_VAL_IDLE_TX;
            endcase
        end
    endfunction

    sacc_alarm u_alarm
    (
        .i_temp(i_conv_result),
        .i_high_th(high_th_q),
        .i_low_th(low_th_q),
        .o_alarm_hit(alarm_hit)
    );

    sacc_crc8 u_crc
    (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_clr(crc_clr),
        .i_en(crc_en),
        .i_byte(tx_d),
        .o_crc(crc_val)
    );

    // command sequencer
    always @*
    begin
        state_d = state_q;
        idx_d = idx_q;
        tx_d = `SACC_VAL_IDLE_TX;
        crc_clr = 1'b0;
        crc_en = 1'b0;
        if (i_bus_reset)
        begin
            state_d = ST_IDLE;
            idx_d = 4'h0;
        end
        else if (i_cmd_valid)
        begin
            idx_d = 4'h0;
            crc_clr = 1'b1;
            if (i_cmd_byte == `SACC_CMD_WRITE_SP)
                state_d = ST_WRITE;
            else if (i_cmd_byte == `SACC_CMD_READ_SP)
                state_d = ST_READ;
            else
                state_d = ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_WRITE:
                begin
                    if (i_rx_valid)
                    begin
                        idx_d = idx_q + 4'h1;
                        if (idx_q == WR_LAST)
                            state_d = ST_IDLE;
                    end
                end
                ST_READ:
                begin
                    if (i_tx_req)
                    begin
                        tx_d = sp_byte(idx_q, temp_q, high_th_q, low_th_q, res_q,
                            crc_val);
                        crc_en = (idx_q < `SACC_OFS_CRC);
                        if (idx_q == `SACC_OFS_CRC)
                            state_d = ST_IDLE;
                        else
                            idx_d = idx_q + 4'h1;
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            state_q <= ST_IDLE;
            idx_q <= 4'h0;
            o_tx_valid <= 1'b0;
            o_tx_byte <= `SACC_VAL_IDLE_TX;
        end
        else
        begin
            state_q <= state_d;
            idx_q <= idx_d;
            // idle reads answer all ones, like a released line
            o_tx_valid <= i_tx_req && !i_bus_reset && !i_cmd_valid;
            if (i_tx_req)
                o_tx_byte <= tx_d;
        end
    end

    // scratchpad user bytes; a partial write keeps what already arrived
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            high_th_q <= `SACC_RST_HIGH_TH;
            low_th_q <= `SACC_RST_LOW_TH;
            res_q <= `SACC_RST_RES;
        end
        else if (state_q == ST_WRITE && i_rx_valid && !i_bus_reset && !i_cmd_valid)
        begin
            case (idx_q)
                4'h0: high_th_q <= i_rx_byte;
                4'h1: low_th_q <= i_rx_byte;
                4'h2: res_q <= i_rx_byte[`SACC_CFG_RES_MSB:`SACC_CFG_RES_LSB];
                default: res_q <= res_q;
            endcase
        end
    end

    // conversion result and alarm flag
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            temp_q <= `SACC_RST_TEMP;
            alarm_q <= 1'b0;
        end
        else if (i_conv_done)
        begin
            temp_q <= i_conv_result;
            // apart from reset, a reading between the thresholds is the only thing that clears it
            alarm_q <= alarm_hit;
        end
    end

    // speed flag; set wins when both arrive together
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
            od_q <= 1'b0;
        else if (i_od_set)
            od_q <= 1'b1;
        else if (i_od_clear)
            od_q <= 1'b0;
    end

    // chain state decode
    always @*
    begin
        chain_d = chain_q;
        if (i_chain_valid)
        begin
            case (i_chain_byte)
                `SACC_CHAIN_CODE_OFF: chain_d = `SACC_CHAIN_OFF;
                `SACC_CHAIN_CODE_ON: chain_d = `SACC_CHAIN_ON;
                `SACC_CHAIN_CODE_DONE: chain_d = `SACC_CHAIN_DONE;
                default: chain_d = chain_q;
            endcase
        end
    end

    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            chain_q <= `SACC_CHAIN_OFF;
            latch_q <= 2'h3;
        end
        else
        begin
            chain_q <= chain_d;
            // pio writes only count in chain off
            if (i_pio_wr_valid && chain_q == `SACC_CHAIN_OFF)
                latch_q <= i_pio_wr_data;
        end
    end

    // pin synchronisers: a level counts once stages two and three agree
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            a_sync_q <= 3'h7;
            b_sync_q <= 3'h7;
            a_pin_q <= 1'b1;
            b_pin_q <= 1'b1;
        end
        else
        begin
            a_sync_q <= {a_sync_q[1:0], i_pio_a_in};
            b_sync_q <= {b_sync_q[1:0], i_pio_b_in};
            if (a_sync_q[1] == a_sync_q[2])
                a_pin_q <= a_sync_q[2];
            if (b_sync_q[1] == b_sync_q[2])
                b_pin_q <= b_sync_q[2];
        end
    end

    // pin drivers and status outputs
    always @(posedge i_sys_clk)
    begin
        if (i_srst)
        begin
            o_pio_a_oe_n <= 1'b1;
            o_pio_b_oe_n <= 1'b1;
            o_pio_a_pullup_en <= 1'b0;
            o_pio_pin_state <= 2'h3;
            o_pio_latch <= 2'h3;
            o_alarm_flag <= 1'b0;
            o_cond_read_enable <= 1'b0;
            o_overdrive_speed_flag <= 1'b0;
            o_resolution_select_low <= 1'b1;
            o_resolution_select_high <= 1'b1;
        end
        else
        begin
            case (chain_q)
                `SACC_CHAIN_ON:
                begin
                    o_pio_a_oe_n <= 1'b1;
                    o_pio_a_pullup_en <= 1'b1;
                    o_pio_b_oe_n <= 1'b1;
                end
                `SACC_CHAIN_DONE:
                begin
                    o_pio_a_oe_n <= 1'b0;
                    o_pio_a_pullup_en <= 1'b0;
                    o_pio_b_oe_n <= 1'b1;
                end
                default:
                begin
                    o_pio_a_oe_n <= latch_q[0];
                    o_pio_a_pullup_en <= 1'b0;
                    o_pio_b_oe_n <= latch_q[1];
                end
            endcase
            o_pio_pin_state <= {b_pin_q, a_pin_q};
            // latches read back as ones outside chain off
            o_pio_latch <= (chain_q == `SACC_CHAIN_OFF) ? latch_q : 2'h3;
            o_alarm_flag <= alarm_q;
            // the enable pin is ignored outside chain on
            o_cond_read_enable <= (chain_q == `SACC_CHAIN_ON) && !b_pin_q;
            o_overdrive_speed_flag <= od_q;
            o_resolution_select_low <= res_q[0];
            o_resolution_select_high <= res_q[1];
        end
    end

    // open-drain pins only ever pull low
    assign o_pio_a_out = 1'b0;
    assign o_pio_b_out = 1'b0;

endmodule // sacc_ctrl
`default_nettype wire

// [core/sacc_map.vh]
// constants of the scratchpad, alarm and chain controller
`ifndef SACC_MAP_VH
`define SACC_MAP_VH

// scratchpad byte addresses
`define SACC_OFS_TEMP_LSB 4'h0
`define SACC_OFS_TEMP_MSB 4'h1
`define SACC_OFS_HIGH_TH 4'h2
`define SACC_OFS_LOW_TH 4'h3
`define SACC_OFS_CONFIG 4'h4
`define SACC_OFS_RSVD5 4'h5
`define SACC_OFS_RSVD6 4'h6
`define SACC_OFS_RSVD7 4'h7
`define SACC_OFS_CRC 4'h8

// reset and constant contents
`define SACC_RST_TEMP 16'h0550
`define SACC_RST_HIGH_TH 8'h55
`define SACC_RST_LOW_TH 8'h00
`define SACC_RST_RES 2'h3
`define SACC_VAL_RSVD5 8'hFF
`define SACC_VAL_RSVD6 8'h0C
`define SACC_VAL_RSVD7 8'h10
`define SACC_VAL_IDLE_TX 8'hFF

// configuration field positions
`define SACC_CFG_RES_LSB 5
`define SACC_CFG_RES_MSB 6
`define SACC_CFG_FIXED_ONES 5'h1F
`define SACC_CFG_TOP_BIT 1'b0

// command codes
`define SACC_CMD_WRITE_SP 8'h4E
`define SACC_CMD_READ_SP 8'hBE

// chain control codes
`define SACC_CHAIN_CODE_OFF 8'h3C
`define SACC_CHAIN_CODE_ON 8'h5A
`define SACC_CHAIN_CODE_DONE 8'h96

// chain state encodings
`define SACC_CHAIN_OFF 2'h0
`define SACC_CHAIN_ON 2'h1
`define SACC_CHAIN_DONE 2'h2

// crc feedback mask for x8+x5+x4+1, reflected
`define SACC_CRC_POLY 8'h8C
`define SACC_CRC_INIT 8'h00

`endif
